// ### verilog/ctr_channel.sv
// Purpose: One 32-bit counter/timer channel with routing, triggering and prescaling
// Assumes: Source and line inputs are asynchronous to clk and are sampled here
// Notes:   Source edges are found by oversampling on clk
//          so source levels must each last longer than one clk period
//
// Functional notes
// - Pulse generation drives generated pulses on the pulse output signal.
// - Pulse output is available internally to peers and timing engines.
// - Pulse output selectable onto any function line or trigger-bus line or star.
// - All function lines are undriven after reset until enabled as outputs.
// - Frequency output selectable onto lines or star, and drives DI/DO sample clock.
// - Reset routing is source 8, gate 9, aux 10, output 12, freq 14; line selects reset to the counter output, so line 14 carries it too.
// - Every default route can be reprogrammed to another permitted line.
// - Nothing counts or generates until the counter is armed.
// - Arm by software command or by selected hardware arm source.
// - Arm combines with start and pause in output; acts as start in input.
// - Start trigger begins generation; continuous runs until software stops it.
// - Finite generation emits programmed pulse count; retrigger restarts it.
// - Configured start trigger comes from the gate input.
// - Pause in edge counting ignores edges at selectable pausing level.
// - Pause in continuous generation suspends output at pausing level.
// - Configured pause trigger comes from the gate input.
// - Peer pulse output and terminal count can feed gate for cascading.
// - Source prescaler divides by eight, two, or is off.
// - Prescaler count is not readable; up to seven edges may be missed.
// - Prescaler is bypassed when source is an internal timebase.
// - 32-bit up/down counter; inputs synchronised to source before use; the hardware arm input is edge-detected on clk instead.
// - Three synchroniser methods chosen by configuration; here SYNC_FAST and SYNC_EXT_FAST behave alike, giving two.
// - Fast methods sample on source rise and act on third rise, pipelined.
// - Slow method samples on delayed source, acts on next source rise.
// - Terminal count pulses or toggles the output, polarity selectable.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ctr_channel
  import ctr_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Register port
  input  wire bus_req_t             bus_req,
  output logic [31:0]               rdata,
  // Timing inputs from pins
  input  wire logic [N_LINES-1:0]   line_in,
  input  wire logic [N_TRIG-1:0]    trig_in,
  input  wire logic                 fast_internal_timebase,
  input  wire logic                 mid_internal_timebase,
  input  wire logic                 slow_internal_timebase,
  // Peer channel signals, same clock
  input  wire logic                 peer_pulse,
  input  wire logic                 peer_tc,
  input  wire logic                 freq_gen_output,
  // Outputs
  output line_drive_t               line_drv,
  output logic [N_TRIG-1:0]         trig_out,
  output logic [N_TRIG-1:0]         trig_oe,
  output logic                      star_out,
  output logic                      counter_pulse_output,
  output logic                      terminal_count,
  output logic                      sample_clk_out,
  output logic                      armed
);

  // Reset release
  logic rst_s1_q;
  logic rst_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_q    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_q    <= rst_s1_q;
    end
  end

  // Two-flop input synchronisers
  localparam int unsigned IN_W = N_LINES + N_TRIG + 3;
  logic [IN_W-1:0] in_s1_q;
  logic [IN_W-1:0] in_s2_q;
  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      in_s1_q <= '0;
      in_s2_q <= '0;
    end
    else
    begin
      in_s1_q <= {slow_internal_timebase, mid_internal_timebase, fast_internal_timebase, trig_in, line_in};
      in_s2_q <= in_s1_q;
    end
  end

  // Configuration registers
  logic [31:0] ctrl_q;
  logic [31:0] route_q;
  logic [31:0] load_q;
  logic [31:0] pulses_q;
  logic [N_LINES-1:0] line_oe_q;
  logic [31:0] line_sel_q;
  logic [N_TRIG-1:0]  trig_oe_q;

  wire app_mode_t  mode      = app_mode_t'(ctrl_q[CTRL_MODE_LO +: 2]);
  wire prescale_t  pre_cfg   = prescale_t'(ctrl_q[CTRL_PRE_LO +: 2]);
  wire sync_mode_t sync_cfg  = sync_mode_t'(ctrl_q[CTRL_SYNC_LO +: 2]);
  wire logic [4:0] src_sel   = route_q[RT_SRC_LO +: RT_SEL_W];
  wire logic [4:0] gate_sel  = route_q[RT_GATE_LO +: RT_SEL_W];
  wire logic [4:0] arm_sel   = route_q[RT_ARM_LO +: RT_SEL_W];

  // Input selection over synchronised inputs
  function automatic logic pick(input logic [4:0] sel, input logic [IN_W-1:0] v,
                                input logic pp, input logic pt);
    logic r;
    r = 1'b0;
    if (sel < SEL_FAST)
      r = v[sel];
    else if (sel == SEL_FAST)
      r = v[N_LINES+N_TRIG];
    else if (sel == SEL_MID)
      r = v[N_LINES+N_TRIG+1];
    else if (sel == SEL_SLOW)
      r = v[N_LINES+N_TRIG+2];
    else if (sel == SEL_PEER)
      r = pp;
    else if (sel == SEL_PEER_TC)
      r = pt;
    return r;
  endfunction : pick

  wire logic src_lvl  = pick(src_sel, in_s2_q, peer_pulse, peer_tc);
  wire logic gate_raw = pick(gate_sel, in_s2_q, peer_pulse, peer_tc);
  wire logic arm_raw  = pick(arm_sel, in_s2_q, peer_pulse, peer_tc);

  // Source edge detect
  logic src_prev_q;
  logic src_prev2_q;
  wire logic src_rise   = src_lvl & ~src_prev_q;
  wire logic dly_rise   = src_prev_q & ~src_prev2_q;
  wire logic internal_src = (src_sel >= SEL_FAST) && (src_sel <= SEL_SLOW);

  // Gate sampling per sync method
  // Slow method samples one clk after the rise, standing in for a delayed source
  logic [FAST_STAGES-1:0] gpipe_q;
  logic gate_slow_q;
  wire logic fast_sync = (sync_cfg != SYNC_SLOW);
  wire logic gate_eff  = fast_sync ? gpipe_q[FAST_STAGES-1] : gate_slow_q;

  // Prescaler
  // Phase is never read back, so a prescaled count may lag the source
  logic [2:0] pre_q;
  wire logic pre_on   = (pre_cfg != PRE_OFF) && !internal_src;
  wire logic [2:0] pre_top = (pre_cfg == PRE_DIV8) ? PRE8_TOP : PRE2_TOP;
  wire logic tick = src_rise && (!pre_on || pre_q == pre_top);

  // Arm and trigger state
  logic arm_prev_q;
  logic armed_q;
  logic running_q;
  logic gate_prev_q;
  logic [31:0] cnt_q;
  logic [31:0] done_q;
  logic pulse_q;
  logic tc_q;

  wire logic cmd_wr  = bus_req.wr && bus_req.addr == REG_CMD;
  wire logic sw_arm  = cmd_wr && bus_req.wdata[0];
  wire logic sw_stop = cmd_wr && bus_req.wdata[1];
  wire logic hardware_arm_input  = ctrl_q[CTRL_HWARM_EN] && arm_raw && !arm_prev_q;
  wire logic arm_now = sw_arm || hardware_arm_input;
  // One-clock edge; a held level would reload the count every clock
  wire logic start_edge = gate_eff && !gate_prev_q;
  wire logic paused  = ctrl_q[CTRL_PAUSE_EN] &&
                       (gate_eff == ctrl_q[CTRL_PAUSE_POL]);
  wire logic is_gen  = (mode == MODE_PULSE);
  wire logic start_ok = !ctrl_q[CTRL_START_EN] || start_edge;
  wire logic retrig  = is_gen && ctrl_q[CTRL_RETRIG] && armed_q && start_edge;
  wire logic do_count = armed_q && running_q && tick && !paused;
  wire logic at_tc   = ctrl_q[CTRL_DOWN] ? (cnt_q == 32'h0000_0000) : (cnt_q == 32'hFFFF_FFFF);
  wire logic tc_ev   = do_count && (is_gen ? (cnt_q == 32'h0000_0000) : at_tc);
  wire logic fin_done = is_gen && !ctrl_q[CTRL_CONT] && tc_ev &&
                        (done_q + 32'h0000_0001 >= pulses_q);

  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      src_prev_q  <= 1'b0;
      src_prev2_q <= 1'b0;
      gpipe_q     <= '0;
      gate_slow_q <= 1'b0;
      pre_q       <= 3'h0;
      arm_prev_q  <= 1'b0;
      gate_prev_q <= 1'b0;
    end
    else
    begin
      src_prev_q  <= src_lvl;
      src_prev2_q <= src_prev_q;
      arm_prev_q  <= arm_raw;
      gate_prev_q <= gate_eff;
      if (src_rise)
      begin
        gpipe_q     <= {gpipe_q[FAST_STAGES-2:0], gate_raw};
      end
      if (dly_rise)
        gate_slow_q <= gate_raw;
      if (arm_now)
        pre_q <= 3'h0;
      else if (src_rise && pre_on)
        pre_q <= (pre_q == pre_top) ? 3'h0 : pre_q + 3'h1;
    end
  end

  // Arm, run and main counter
  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      armed_q   <= 1'b0;
      running_q <= 1'b0;
      cnt_q     <= 32'h0000_0000;
      done_q    <= 32'h0000_0000;
      pulse_q   <= 1'b0;
      tc_q      <= 1'b0;
    end
    else
    begin
      tc_q <= tc_ev;
      if (sw_stop || (fin_done && !ctrl_q[CTRL_RETRIG]))
      begin
        armed_q   <= 1'b0;
        running_q <= 1'b0;
      end
      // Retriggerable finite run stays armed for the next start
      else if (fin_done)
        running_q <= 1'b0;
      else if (arm_now)
      begin
        armed_q   <= 1'b1;
        running_q <= !is_gen || !ctrl_q[CTRL_START_EN];
        cnt_q     <= load_q;
        done_q    <= 32'h0000_0000;
      end
      else if (armed_q && !running_q && start_ok)
      begin
        running_q <= 1'b1;
        cnt_q     <= load_q;
        done_q    <= 32'h0000_0000;
      end
      else if (retrig)
      begin
        cnt_q  <= load_q;
        done_q <= 32'h0000_0000;
      end
      else if (do_count)
      begin
        if (is_gen && cnt_q == 32'h0000_0000)
        begin
          cnt_q  <= load_q;
          done_q <= done_q + 32'h0000_0001;
        end
        else if (ctrl_q[CTRL_DOWN] || is_gen)
          cnt_q <= cnt_q - 32'h0000_0001;
        else
          cnt_q <= cnt_q + 32'h0000_0001;
      end
      if (arm_now)
        pulse_q <= 1'b0;
      else if (tc_ev && ctrl_q[CTRL_TOGGLE])
        pulse_q <= ~pulse_q;
      else if (!ctrl_q[CTRL_TOGGLE])
        pulse_q <= tc_ev;
    end
  end

  wire logic ctr_out = pulse_q ^ ctrl_q[CTRL_OUT_POL];
  wire logic star_freq = ctrl_q[CTRL_STAR];

  // Register writes
  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      ctrl_q     <= CTRL_RST;
      route_q    <= ROUTE_RST;
      load_q     <= 32'h0000_0000;
      pulses_q   <= 32'h0000_0001;
      line_oe_q  <= '0;
      line_sel_q <= {8'h00, 8'h00, 8'h00, 8'h00};
      trig_oe_q  <= '0;
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        REG_CTRL:     ctrl_q     <= bus_req.wdata;
        REG_ROUTE:    route_q    <= bus_req.wdata;
        REG_LOAD:     load_q     <= bus_req.wdata;
        REG_PULSES:   pulses_q   <= bus_req.wdata;
        REG_LINE_OE:  {trig_oe_q, line_oe_q} <= bus_req.wdata[N_TRIG+N_LINES-1:0];
        REG_LINE_SEL: line_sel_q <= bus_req.wdata;
        default:      ;
      endcase
    end
  end

  // Per-line output source: bit pair selects counter or frequency output
  logic [N_LINES-1:0] line_val;
  genvar gi;
  generate
    for (gi = 0; gi < N_LINES; gi++)
    begin : g_line
      wire logic [1:0] osel = line_sel_q[2*gi +: 2];
      assign line_val[gi] = (osel == OSEL_FREQ) ? freq_gen_output : ctr_out;
    end
  endgenerate

  // Read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    case (bus_req.addr)
      REG_CTRL:     rd_mux = ctrl_q;
      REG_ROUTE:    rd_mux = route_q;
      REG_LOAD:     rd_mux = load_q;
      REG_PULSES:   rd_mux = pulses_q;
      REG_COUNT:    rd_mux = cnt_q;
      REG_STATUS:   rd_mux = {29'h0, running_q, armed_q, pulse_q};
      REG_LINE_OE:  rd_mux = {8'h00, trig_oe_q, line_oe_q};
      REG_LINE_SEL: rd_mux = line_sel_q;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_q)
  begin
    if (!rst_q)
    begin
      rdata                <= 32'h0000_0000;
      line_drv             <= '0;
      trig_out             <= '0;
      trig_oe              <= '0;
      star_out             <= 1'b0;
      counter_pulse_output <= 1'b0;
      terminal_count       <= 1'b0;
      sample_clk_out       <= 1'b0;
      armed                <= 1'b0;
    end
    else
    begin
      rdata                <= bus_req.rd ? rd_mux : 32'h0000_0000;
      line_drv.o           <= line_val;
      line_drv.oe          <= line_oe_q;
      trig_out             <= {N_TRIG{ctr_out}};
      trig_oe              <= trig_oe_q;
      star_out             <= star_freq ? freq_gen_output : ctr_out;
      counter_pulse_output <= ctr_out;
      terminal_count       <= tc_q;
      sample_clk_out       <= freq_gen_output;
      armed                <= armed_q;
    end
  end

endmodule : ctr_channel
`default_nettype wire

// ### common/ctr_pkg.sv
// Purpose: Shared constants and types for the counter/timer channel
// Assumes: 100 MHz system clock, 16 function lines, 8 trigger-bus lines
// Notes:   Register offsets are word-indexed byte addresses
package ctr_pkg;

  localparam int unsigned N_LINES   = 16;
  localparam int unsigned N_TRIG    = 8;
  localparam int unsigned N_CTR     = 4;
  localparam int unsigned CNT_W     = 32;
  localparam int unsigned ADDR_W    = 8;

  // Register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ROUTE    = 8'h04;
  localparam logic [7:0] REG_LOAD     = 8'h08;
  localparam logic [7:0] REG_PULSES   = 8'h0C;
  localparam logic [7:0] REG_COUNT    = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_LINE_OE  = 8'h18;
  localparam logic [7:0] REG_LINE_SEL = 8'h1C;
  localparam logic [7:0] REG_CMD      = 8'h20;

  // Control field positions
  localparam int unsigned CTRL_MODE_LO   = 0;   // 2 bits
  localparam int unsigned CTRL_DOWN      = 2;
  localparam int unsigned CTRL_TOGGLE    = 3;
  localparam int unsigned CTRL_OUT_POL   = 4;
  localparam int unsigned CTRL_PRE_LO    = 5;   // 2 bits
  localparam int unsigned CTRL_SYNC_LO   = 7;   // 2 bits
  localparam int unsigned CTRL_START_EN  = 9;
  localparam int unsigned CTRL_PAUSE_EN  = 10;
  localparam int unsigned CTRL_PAUSE_POL = 11;
  localparam int unsigned CTRL_RETRIG    = 12;
  localparam int unsigned CTRL_HWARM_EN  = 13;
  localparam int unsigned CTRL_CONT      = 14;
  localparam int unsigned CTRL_STAR      = 15;

  // Route field positions (5-bit selectors)
  localparam int unsigned RT_SRC_LO  = 0;
  localparam int unsigned RT_GATE_LO = 5;
  localparam int unsigned RT_ARM_LO  = 10;
  localparam int unsigned RT_AUX_LO  = 15;
  localparam int unsigned RT_SEL_W   = 5;

  // Selector codes: 0..15 lines, 16..23 trigger bus, then internal sources
  localparam logic [4:0] SEL_FAST  = 5'h18;
  localparam logic [4:0] SEL_MID   = 5'h19;
  localparam logic [4:0] SEL_SLOW  = 5'h1A;
  localparam logic [4:0] SEL_PEER  = 5'h1B;   // peer pulse output
  localparam logic [4:0] SEL_PEER_TC = 5'h1C; // peer terminal count

  // Output line selector codes (per line, 2 bits)
  localparam logic [1:0] OSEL_CTR  = 2'h0;
  localparam logic [1:0] OSEL_FREQ = 2'h1;

  // Default routes for channel 0: source/A 8, gate/Z 9, aux/B 10, output 12
  localparam logic [31:0] ROUTE_RST = 32'h0005_2528;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [3:0]  OUT_LINE_DEF  = 4'hC;
  localparam logic [3:0]  FREQ_LINE_DEF = 4'hE;

  typedef enum logic [1:0] {PRE_OFF, PRE_DIV8, PRE_DIV2} prescale_t;
  typedef enum logic [1:0] {SYNC_FAST, SYNC_EXT_FAST, SYNC_SLOW} sync_mode_t;
  typedef enum logic [1:0] {MODE_EDGE, MODE_PULSE} app_mode_t;

  localparam logic [2:0] PRE8_TOP = 3'h7;
  localparam logic [2:0] PRE2_TOP = 3'h1;

  // Pipeline depth before a sampled input takes effect
  localparam int unsigned FAST_STAGES = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  typedef struct packed {
    logic [N_LINES-1:0] o;
    logic [N_LINES-1:0] oe;
  } line_drive_t;

endpackage : ctr_pkg

// ### tb/ctr_channel_asserts.sv
// Purpose: Port-level checks on the counter/timer channel
// Assumes: One clock domain, async active-low reset
// Notes:   Latencies allow one or two register stages
`timescale 1ns/100ps
`default_nettype none
module ctr_channel_asserts
  import ctr_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Register port
  input  wire bus_req_t           bus_req,
  input  wire logic [31:0]        rdata,
  // Observed signals
  input  wire logic               freq_gen_output,
  input  wire line_drive_t        line_drv,
  input  wire logic [N_TRIG-1:0]  trig_oe,
  input  wire logic               counter_pulse_output,
  input  wire logic               terminal_count,
  input  wire logic               sample_clk_out,
  input  wire logic               armed
);
  logic [2:0] up_q;
  logic       cmd_wr;
  logic       oe_wr;
  logic       ctrl_wr;

  assign cmd_wr  = bus_req.wr && bus_req.addr == REG_CMD;
  assign oe_wr   = bus_req.wr && bus_req.addr == REG_LINE_OE;
  assign ctrl_wr = bus_req.wr && bus_req.addr == REG_CTRL;

  // Internal reset lags rst_n by two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_tc_single: assert property (terminal_count |=> !terminal_count)
    else $error("terminal count longer than one cycle");
  a_tc_armed: assert property (terminal_count |-> $past(armed))
    else $error("terminal count while not armed");
  a_arm_cmd: assert property (cmd_wr && bus_req.wdata[1:0] == 2'b01 |-> ##[1:2] armed)
    else $error("arm command did not arm");
  a_stop_cmd: assert property (cmd_wr && bus_req.wdata[1] |-> ##[1:2] !armed)
    else $error("stop command did not disarm");
  a_oe_by_write: assert property ($changed(line_drv.oe) |-> $past(oe_wr) || $past(oe_wr, 2))
    else $error("line drive enable changed without a write");
  a_trig_oe_write: assert property ($changed(trig_oe) |-> $past(oe_wr) || $past(oe_wr, 2))
    else $error("trigger bus enable changed without a write");
  a_sample_clk: assert property (up_q == 3'h7 |-> sample_clk_out == $past(freq_gen_output))
    else $error("sample clock does not follow frequency output");
  a_pulse_armed: assert property ($changed(counter_pulse_output) |->
    $past(armed) || $past(armed, 2) || $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("pulse output moved while idle");
endmodule : ctr_channel_asserts

bind ctr_channel ctr_channel_asserts i_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
  .freq_gen_output(freq_gen_output), .line_drv(line_drv), .trig_oe(trig_oe),
  .counter_pulse_output(counter_pulse_output), .terminal_count(terminal_count),
  .sample_clk_out(sample_clk_out), .armed(armed));
`default_nettype wire

// ### tb/ctr_far_side.sv
// Purpose: External timing source and gate level for the channel
// Assumes: Link period 160 ns, phase unrelated to clk
// Notes:   Source stands low between frames
`timescale 1ns/100ps
`default_nettype none
module ctr_far_side
(
  // Frame control
  input  wire logic       go,
  input  wire logic [7:0] n_edges,
  input  wire logic       gate_req,
  // Timing lines
  output logic            src,
  output logic            gate,
  output logic            done
);
  initial
  begin
    src  = 1'b0;
    done = 1'b0;
  end
  assign gate = gate_req;
  // Odd offset keeps source edges off the clk grid
  always @(posedge go)
  begin
    done = 1'b0;
    #37;
    repeat (n_edges)
    begin
      src = 1'b1;
      #80;
      src = 1'b0;
      #80;
    end
    done = 1'b1;
  end
endmodule : ctr_far_side
`default_nettype wire

// ### tb/counter_trigger_prescale_sync_tb_top.sv
// Purpose: Self-checking bench for the counter/timer channel
// Assumes: Source on line 8, gate on line 9 from the far-side model
// Notes:   Counts compared as deltas; value at arming is not fixed
`timescale 1ns/100ps
`default_nettype none
module counter_trigger_prescale_sync_tb_top
  import ctr_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  bus_req_t          bus_req = '0;
  logic [31:0]       rdata;
  logic              src;
  logic              gate;
  logic              done;
  logic              gate_req = 1'b0;
  logic              go = 1'b0;
  logic [7:0]        n_edges = 8'h00;
  logic              freq = 1'b0;
  logic              peer_pulse = 1'b0;
  line_drive_t       line_drv;
  logic [N_TRIG-1:0] trig_out;
  logic [N_TRIG-1:0] trig_oe;
  logic              star_out;
  logic              pulse_out;
  logic              tc;
  logic              sample_clk;
  logic              armed;
  int                errors = 0;
  int                checks = 0;
  int                tc_n = 0;
  int                tc0;
  logic [31:0]       v;
  logic [31:0]       c0;

  always #5 clk = ~clk;
  always @(posedge clk) if (tc === 1'b1) tc_n <= tc_n + 1;

  ctr_far_side i_far (.go(go), .n_edges(n_edges), .gate_req(gate_req), .src(src), .gate(gate), .done(done));

  ctr_channel i_dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
    .line_in({6'h00, gate, src, 8'h00}), .trig_in(8'h00), .fast_internal_timebase(1'b0),
    .mid_internal_timebase(1'b0), .slow_internal_timebase(1'b0), .peer_pulse(peer_pulse),
    .peer_tc(1'b0), .freq_gen_output(freq), .line_drv(line_drv), .trig_out(trig_out),
    .trig_oe(trig_oe), .star_out(star_out), .counter_pulse_output(pulse_out),
    .terminal_count(tc), .sample_clk_out(sample_clk), .armed(armed));

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask : rd

  task automatic edges(input logic [7:0] n);
    int i;
    @(posedge clk);
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5000 && done !== 1'b1; i++)
      @(posedge clk);
    cmp("frame_done", 32'h0000_0001, {31'h0, done});
    go <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : edges

  // Reads the count, sends n source edges, expects the count to move by exp
  task automatic count_delta(input logic [7:0] n, input logic [31:0] exp);
    rd(REG_COUNT, c0);
    edges(n);
    rd(REG_COUNT, v);
    cmp("count_delta", c0 + exp, v);
  endtask : count_delta

  task automatic t_reset;
    cmp("line_oe", 32'h0000_0000, {16'h0000, line_drv.oe});
    cmp("trig_oe", 32'h0000_0000, {24'h00_0000, trig_oe});
    rd(REG_CTRL, v);
    cmp("ctrl", CTRL_RST, v);
    rd(REG_ROUTE, v);
    cmp("route", ROUTE_RST, v);
    rd(8'h3C, v);
    cmp("unmapped", 32'h0000_0000, v);
    wr(REG_ROUTE, {ROUTE_RST[31:5], 5'h0B});
    rd(REG_ROUTE, v);
    cmp("route_src", {ROUTE_RST[31:5], 5'h0B}, v);
    wr(REG_ROUTE, ROUTE_RST);
  endtask : t_reset

  task automatic t_count;
    wr(REG_CMD, 32'h0000_0002);
    count_delta(8'h04, 32'h0000_0000);
    wr(REG_CMD, 32'h0000_0001);
    count_delta(8'h05, 32'h0000_0005);
    // Gate needs source edges to pass the synchroniser
    wr(REG_CTRL, 32'h0000_0C00);
    gate_req <= 1'b1;
    edges(8'h04);
    count_delta(8'h05, 32'h0000_0000);
    gate_req <= 1'b0;
    edges(8'h04);
    count_delta(8'h04, 32'h0000_0004);
  endtask : t_count

  task automatic t_prescale;
    wr(REG_CTRL, 32'h0000_0020);
    wr(REG_CMD, 32'h0000_0002);
    wr(REG_CMD, 32'h0000_0001);
    count_delta(8'h10, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_0040);
    wr(REG_CMD, 32'h0000_0002);
    wr(REG_CMD, 32'h0000_0001);
    count_delta(8'h06, 32'h0000_0003);
    wr(REG_CMD, 32'h0000_0002);
  endtask : t_prescale

  task automatic t_pulse;
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_LOAD, 32'h0000_0001);
    wr(REG_PULSES, 32'h0000_0003);
    tc0 = tc_n;
    wr(REG_CMD, 32'h0000_0001);
    edges(8'h0C);
    cmp("finite_tc", 32'h0000_0003, tc_n - tc0);
    cmp("finite_armed", 32'h0000_0000, {31'h0, armed});
    wr(REG_CTRL, 32'h0000_4001);
    tc0 = tc_n;
    wr(REG_CMD, 32'h0000_0001);
    edges(8'h0C);
    cmp("cont_armed", 32'h0000_0001, {31'h0, armed});
    cmp("cont_runs", 32'h0000_0001, {31'h0, (tc_n - tc0) > 3});
    wr(REG_CMD, 32'h0000_0002);
    tc0 = tc_n;
    edges(8'h06);
    cmp("stopped_tc", 32'h0000_0000, tc_n - tc0);
  endtask : t_pulse

  // Finite run of one pulse waits for the gate, then restarts on a later gate rise
  task automatic t_trigger;
    wr(REG_CTRL, 32'h0000_1201);
    wr(REG_PULSES, 32'h0000_0001);
    tc0 = tc_n;
    wr(REG_CMD, 32'h0000_0001);
    edges(8'h06);
    cmp("wait_start", 32'h0000_0000, tc_n - tc0);
    gate_req <= 1'b1;
    edges(8'h06);
    cmp("started", 32'h0000_0001, tc_n - tc0);
    gate_req <= 1'b0;
    edges(8'h04);
    gate_req <= 1'b1;
    edges(8'h06);
    cmp("retrig_tc", 32'h0000_0002, tc_n - tc0);
    cmp("retrig_armed", 32'h0000_0001, {31'h0, armed});
    wr(REG_CMD, 32'h0000_0002);
    gate_req <= 1'b0;
    wr(REG_CTRL, 32'h0000_2000);
    cmp("hw_idle", 32'h0000_0000, {31'h0, armed});
    gate_req <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("hw_armed", 32'h0000_0001, {31'h0, armed});
    gate_req <= 1'b0;
    wr(REG_CMD, 32'h0000_0002);
  endtask : t_trigger

  // Slow method pauses after one source rise; peer output as gate
  task automatic t_sync;
    wr(REG_CTRL, 32'h0000_0D00);
    wr(REG_CMD, 32'h0000_0001);
    gate_req <= 1'b1;
    edges(8'h01);
    count_delta(8'h03, 32'h0000_0000);
    gate_req <= 1'b0;
    edges(8'h01);
    count_delta(8'h03, 32'h0000_0003);
    wr(REG_ROUTE, {ROUTE_RST[31:10], SEL_PEER, ROUTE_RST[4:0]});
    peer_pulse <= 1'b1;
    count_delta(8'h05, 32'h0000_0001);
    peer_pulse <= 1'b0;
    wr(REG_CMD, 32'h0000_0002);
    wr(REG_ROUTE, ROUTE_RST);
  endtask : t_sync

  task automatic t_lines;
    wr(REG_LINE_OE, 32'h00FF_5000);
    wr(REG_LINE_SEL, 32'h1000_0000);
    wr(REG_CTRL, 32'h0000_8010);
    freq <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("oe", 32'h0000_5000, {16'h0000, line_drv.oe});
    cmp("trig_oe_on", 32'h0000_00FF, {24'h00_0000, trig_oe});
    cmp("line12", 32'h0000_0003, {30'h0, pulse_out, line_drv.o[12]});
    cmp("trig_out", 32'h0000_00FF, {24'h00_0000, trig_out});
    cmp("freq_hi", 32'h0000_0007, {29'h0, line_drv.o[14], star_out, sample_clk});
    freq <= 1'b0;
    repeat (4) @(posedge clk);
    cmp("freq_lo", 32'h0000_0000, {29'h0, line_drv.o[14], star_out, sample_clk});
  endtask : t_lines

  task automatic end_sim;
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial
  begin
    #200us;
    errors++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_count();
    t_prescale();
    t_pulse();
    t_trigger();
    t_sync();
    t_lines();
    end_sim();
  end
endmodule : counter_trigger_prescale_sync_tb_top
`default_nettype wire
